// file: include/access_layer_consts.svh
`ifndef ACCESS_LAYER_CONSTS_SVH
`define ACCESS_LAYER_CONSTS_SVH

// Register offsets
`define OFS_PORT_CONTROL_B        4'h3
`define OFS_KEY_STATUS            4'h7
`define OFS_SYSTEM_RESET_REQUEST  4'h8
`define OFS_PORT_CLOCK_CONTROL    4'h9
`define OFS_SYSTEM_CONTROL        4'hA
`define OFS_SYSTEM_STATUS         4'hB
`define OFS_CRC_STATUS            4'hC

// Port control B fields
`define BIT_NEG_ACK_DISABLE          4
`define BIT_CONTENTION_DETECT_DISABLE 3
`define BIT_PORT_DISABLE             2

// Key status fields
`define BIT_USER_ROW_KEY             5
`define BIT_MEMORY_PROGRAM_KEY       4
`define BIT_FULL_ERASE_KEY           3

// System control fields
`define BIT_USER_ROW_FINISH          1
`define BIT_SYSTEM_CLOCK_REQUEST     0

// System status fields
`define BIT_SYSTEM_RESET_ACTIVE      5
`define BIT_SYSTEM_SLEEPING          4
`define BIT_MEM_PROGRAM_ALLOWED      3
`define BIT_USER_ROW_PROGRAM_ALLOWED 2
`define BIT_MEMORY_LOCKED            0

// Values
`define RESET_SIGNATURE           8'h59
`define CLOCK_SELECT_16MHZ        2'h1
`define CLOCK_SELECT_8MHZ         2'h2
`define CLOCK_SELECT_4MHZ         2'h3
`define CLOCK_SELECT_DEFAULT      2'h3
`define CRC_STATUS_OFF            3'h0
`define CRC_STATUS_BUSY           3'h1
`define CRC_STATUS_PASS           3'h2
`define CRC_STATUS_FAIL           3'h4

// Synchronised input vector layout
`define SYNC_WIDTH                10
`define SYNC_SYS_RESET            0
`define SYNC_SLEEPING             1
`define SYNC_LOCKED               2
`define SYNC_MEM_PROG_ALLOWED     3
`define SYNC_UROW_ALLOWED         4
`define SYNC_MEM_PROG_DONE        5
`define SYNC_ERASE_DONE           6
`define SYNC_CRC_LSB              7
`define SYNC_LOCKED_RESET         10'h004

`endif

// file: include/access_layer_pkg.sv
`include "access_layer_consts.svh"

package access_layer_pkg;

    typedef enum logic [1:0] {
        PORT_OFF = 2'b01,
        PORT_ON  = 2'b10
    } port_state_type;

    typedef struct packed {
        port_state_type            state;
        logic [`SYNC_WIDTH-1:0]    sync1;
        logic [`SYNC_WIDTH-1:0]    sync2;
        logic                      neg_ack_disable;
        logic                      contention_detect_disable;
        logic                      user_row_key_active;
        logic                      memory_program_key;
        logic                      full_erase_key_active;
        logic                      system_reset_hold;
        logic [1:0]                port_clock_select;
        logic                      user_row_finish;
        logic                      system_clock_request;
        logic                      system_reset_active;
        logic [7:0]                rd_data;
        logic                      finish_pulse;
        logic                      neg_ack_send;
    } access_state_type;

endpackage

// file: rtl/access_layer_regs.sv
`timescale 1ns/1ps
`include "access_layer_consts.svh"

module access_layer_regs
    import access_layer_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Register access from the port's instruction layer, same clock
    input  wire logic [3:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Events from the port's own layers, same clock
    input  wire logic       port_enable_event,
    input  wire logic       user_row_key_decoded,
    input  wire logic       memory_program_key_decoded,
    input  wire logic       full_erase_key_decoded,
    input  wire logic       neg_ack_request,
    // System domain status, asynchronous to this clock
    input  wire logic       sys_reset_in,
    input  wire logic       sys_sleeping_in,
    input  wire logic       memory_locked_in,
    input  wire logic       mem_program_allowed_in,
    input  wire logic       user_row_program_allowed_in,
    input  wire logic       mem_program_done_in,
    input  wire logic       erase_done_in,
    input  wire logic [2:0] crc_status_in,
    // Controls
    output logic            phy_enable,
    output logic            port_clock_request,
    output logic [1:0]      port_clock_select,
    output logic            contention_detect_enable,
    output logic            neg_ack_send,
    output logic            system_reset_out,
    output logic            system_clock_request,
    output logic            user_row_finish_pulse,
    output logic            user_row_key_active,
    output logic            memory_program_key,
    output logic            full_erase_key_active
);

    access_state_type cur_reg;
    access_state_type cur_next;

    function automatic access_state_type port_defaults(input access_state_type s);
        access_state_type d;
        d                           = s;
        d.neg_ack_disable           = 1'b0;
        d.contention_detect_disable = 1'b0;
        d.user_row_key_active       = 1'b0;
        d.memory_program_key        = 1'b0;
        d.full_erase_key_active     = 1'b0;
        d.port_clock_select         = `CLOCK_SELECT_DEFAULT;
        d.user_row_finish           = 1'b0;
        d.system_clock_request      = 1'b0;
        d.neg_ack_send              = 1'b0;
        d.finish_pulse              = 1'b0;
        return d;
    endfunction

    logic [7:0] read_value;
    logic       wr_hit;
    logic       on;
    logic [`SYNC_WIDTH-1:0] sv;

    always_comb begin
        cur_next = cur_reg;
        sv       = cur_reg.sync2;
        on       = (cur_reg.state == PORT_ON);
        wr_hit   = reg_wr && on;
        // Only the second stage is read by logic
        // Bit order follows the SYNC_ layout in the constants header
        cur_next.sync1 = {crc_status_in, erase_done_in, mem_program_done_in,
                          user_row_program_allowed_in, mem_program_allowed_in,
                          memory_locked_in, sys_sleeping_in, sys_reset_in};
        cur_next.sync2 = cur_reg.sync1;
        cur_next.finish_pulse = 1'b0;
        cur_next.neg_ack_send = on && neg_ack_request && !cur_reg.neg_ack_disable;

        // Register read mux; unused bits stay zero
        read_value = 8'h00;
        case (reg_addr)
            `OFS_PORT_CONTROL_B: begin
                read_value[`BIT_NEG_ACK_DISABLE]           = cur_reg.neg_ack_disable;
                read_value[`BIT_CONTENTION_DETECT_DISABLE] = cur_reg.contention_detect_disable;
            end
            `OFS_KEY_STATUS: begin
                read_value[`BIT_USER_ROW_KEY]       = cur_reg.user_row_key_active;
                read_value[`BIT_MEMORY_PROGRAM_KEY] = cur_reg.memory_program_key;
                read_value[`BIT_FULL_ERASE_KEY]     = cur_reg.full_erase_key_active;
            end
            `OFS_SYSTEM_RESET_REQUEST: begin
                read_value[0] = cur_reg.system_reset_hold;
            end
            `OFS_PORT_CLOCK_CONTROL: begin
                read_value[1:0] = cur_reg.port_clock_select;
            end
            `OFS_SYSTEM_CONTROL: begin
                read_value[`BIT_USER_ROW_FINISH]      = cur_reg.user_row_finish;
                read_value[`BIT_SYSTEM_CLOCK_REQUEST] = cur_reg.system_clock_request;
            end
            `OFS_SYSTEM_STATUS: begin
                read_value[`BIT_SYSTEM_RESET_ACTIVE]      = cur_reg.system_reset_active;
                read_value[`BIT_SYSTEM_SLEEPING]          = sv[`SYNC_SLEEPING];
                read_value[`BIT_MEM_PROGRAM_ALLOWED]      = sv[`SYNC_MEM_PROG_ALLOWED];
                read_value[`BIT_USER_ROW_PROGRAM_ALLOWED] = sv[`SYNC_UROW_ALLOWED];
                read_value[`BIT_MEMORY_LOCKED]            = sv[`SYNC_LOCKED];
            end
            `OFS_CRC_STATUS: begin
                read_value[2:0] = sv[`SYNC_CRC_LSB +: 3];
            end
            default: begin
                read_value = 8'h00;
            end
        endcase
        // Only the access instructions reach this port; no CPU path exists
        if (reg_rd && on) begin
            cur_next.rd_data = read_value;
        end

        // Sticky system reset flag: a new reset beats the clear from a read
        if (reg_rd && on && reg_addr == `OFS_SYSTEM_STATUS) begin
            cur_next.system_reset_active = 1'b0;
        end
        if (sv[`SYNC_SYS_RESET] || cur_reg.system_reset_hold) begin
            cur_next.system_reset_active = 1'b1;
        end

        // Keys set by decode; program and erase keys auto clear when their sequence finishes
        if (user_row_key_decoded) begin
            cur_next.user_row_key_active = 1'b1;
        end
        if (sv[`SYNC_MEM_PROG_DONE]) begin
            cur_next.memory_program_key = 1'b0;
        end
        if (memory_program_key_decoded) begin
            cur_next.memory_program_key = 1'b1;
        end
        if (sv[`SYNC_ERASE_DONE]) begin
            cur_next.full_erase_key_active = 1'b0;
        end
        if (full_erase_key_decoded) begin
            cur_next.full_erase_key_active = 1'b1;
        end

        if (wr_hit) begin
            case (reg_addr)
                `OFS_PORT_CONTROL_B: begin
                    cur_next.neg_ack_disable = reg_wdata[`BIT_NEG_ACK_DISABLE];
                    cur_next.contention_detect_disable =
                        reg_wdata[`BIT_CONTENTION_DETECT_DISABLE];
                end
                `OFS_KEY_STATUS: begin
                    if (!reg_wdata[`BIT_USER_ROW_KEY] && !user_row_key_decoded) begin
                        cur_next.user_row_key_active = 1'b0;
                    end
                end
                `OFS_SYSTEM_RESET_REQUEST: begin
                    cur_next.system_reset_hold = (reg_wdata == `RESET_SIGNATURE);
                end
                `OFS_PORT_CLOCK_CONTROL: begin
                    // Reserved code 0 is refused, the field keeps its value
                    if (reg_wdata[1:0] != 2'h0) begin
                        cur_next.port_clock_select = reg_wdata[1:0];
                    end
                end
                `OFS_SYSTEM_CONTROL: begin
                    cur_next.system_clock_request =
                        reg_wdata[`BIT_SYSTEM_CLOCK_REQUEST];
                    // Finish only counts with the user-row key; RAM state is not checked
                    if (cur_reg.user_row_key_active) begin
                        cur_next.user_row_finish = reg_wdata[`BIT_USER_ROW_FINISH];
                        cur_next.finish_pulse    = reg_wdata[`BIT_USER_ROW_FINISH];
                    end
                end
                default: begin
                end
            endcase
        end

        case (cur_reg.state)
            PORT_OFF: begin
                if (port_enable_event) begin
                    cur_next                      = port_defaults(cur_next);
                    cur_next.system_clock_request = 1'b1;
                    cur_next.state                = PORT_ON;
                end
            end
            PORT_ON: begin
                if (wr_hit && reg_addr == `OFS_PORT_CONTROL_B &&
                    reg_wdata[`BIT_PORT_DISABLE]) begin
                    // Full port teardown; system reset hold is kept on purpose
                    cur_next       = port_defaults(cur_next);
                    cur_next.state = PORT_OFF;
                end
            end
            default: begin
                cur_next.state = PORT_OFF;
            end
        endcase
    end

    // Only rst_n resets this logic; the system reset request never does
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg                           <= '0;
            cur_reg.state                     <= PORT_OFF;
            cur_reg.sync1                     <= `SYNC_LOCKED_RESET;
            cur_reg.sync2                     <= `SYNC_LOCKED_RESET;
            cur_reg.port_clock_select         <= `CLOCK_SELECT_DEFAULT;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign reg_rdata                = cur_reg.rd_data;
    assign phy_enable               = cur_reg.state[1];
    assign port_clock_request       = cur_reg.state[1];
    assign port_clock_select        = cur_reg.port_clock_select;
    assign contention_detect_enable = !cur_reg.contention_detect_disable;
    assign neg_ack_send             = cur_reg.neg_ack_send;
    assign system_reset_out         = cur_reg.system_reset_hold;
    assign system_clock_request     = cur_reg.system_clock_request;
    assign user_row_finish_pulse    = cur_reg.finish_pulse;
    assign user_row_key_active      = cur_reg.user_row_key_active;
    assign memory_program_key       = cur_reg.memory_program_key;
    assign full_erase_key_active    = cur_reg.full_erase_key_active;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_disable_write;
        reg_wr && phy_enable && reg_addr == `OFS_PORT_CONTROL_B && reg_wdata[`BIT_PORT_DISABLE];
    endsequence

    sequence s_torn_down;
        !phy_enable && !port_clock_request && !system_clock_request &&
        !user_row_key_active && !memory_program_key && !full_erase_key_active;
    endsequence

    property p_disable_teardown;
        s_disable_write |=> s_torn_down;
    endproperty
    a_disable_teardown: assert property (p_disable_teardown)
        else $error("port disable did not tear down the port");

    property p_nack_muted;
        cur_reg.neg_ack_disable && neg_ack_request |=> !neg_ack_send;
    endproperty
    a_nack_muted: assert property (p_nack_muted)
        else $error("negative acknowledge not muted by its disable bit");

    property p_nack_gate;
        neg_ack_send |-> !$past(cur_reg.neg_ack_disable) && $past(neg_ack_request);
    endproperty
    a_nack_gate: assert property (p_nack_gate)
        else $error("negative acknowledge sent while disabled");

    property p_contention;
        reg_wr && phy_enable && reg_addr == `OFS_PORT_CONTROL_B &&
        !reg_wdata[`BIT_PORT_DISABLE]
        |=> contention_detect_enable == !$past(reg_wdata[`BIT_CONTENTION_DETECT_DISABLE]);
    endproperty
    a_contention: assert property (p_contention)
        else $error("contention detect enable does not follow its write");

    property p_reset_signature;
        reg_wr && phy_enable && reg_addr == `OFS_SYSTEM_RESET_REQUEST
        |=> system_reset_out == ($past(reg_wdata) == `RESET_SIGNATURE);
    endproperty
    a_reset_signature: assert property (p_reset_signature)
        else $error("system reset hold does not match the written signature");

    property p_reset_readback;
        reg_rd && phy_enable && reg_addr == `OFS_SYSTEM_RESET_REQUEST
        |=> reg_rdata == {7'h00, $past(system_reset_out)};
    endproperty
    a_reset_readback: assert property (p_reset_readback)
        else $error("reset request read value wrong");

    property p_finish_needs_key;
        user_row_finish_pulse |-> $past(user_row_key_active) && $past(reg_wr);
    endproperty
    a_finish_needs_key: assert property (p_finish_needs_key)
        else $error("user row finish accepted without key");

    property p_enable_clock_request;
        !phy_enable && port_enable_event |=> phy_enable && system_clock_request
            && port_clock_select == `CLOCK_SELECT_DEFAULT;
    endproperty
    a_enable_clock_request: assert property (p_enable_clock_request)
        else $error("enable did not request the system clock at default speed");

    property p_system_reset_active_sticky;
        cur_reg.system_reset_hold |=> cur_reg.system_reset_active [*2];
    endproperty
    a_system_reset_active_sticky: assert property (p_system_reset_active_sticky)
        else $error("held system reset not flagged");

    property p_clock_select_legal;
        port_clock_select != 2'h0;
    endproperty
    a_clock_select_legal: assert property (p_clock_select_legal)
        else $error("reserved port clock code selected");

    property p_system_clock_request_write;
        reg_wr && phy_enable && reg_addr == `OFS_SYSTEM_CONTROL
        |=> system_clock_request == $past(reg_wdata[`BIT_SYSTEM_CLOCK_REQUEST]);
    endproperty
    a_system_clock_request_write: assert property (p_system_clock_request_write)
        else $error("system clock request does not follow its write");

    property p_urow_key_write;
        reg_wr && phy_enable && reg_addr == `OFS_KEY_STATUS &&
        !reg_wdata[`BIT_USER_ROW_KEY] && !user_row_key_decoded |=> !user_row_key_active;
    endproperty
    a_urow_key_write: assert property (p_urow_key_write)
        else $error("user row key not cleared by its write");

endmodule

// file: tb/system_domain_model.sv
`timescale 1ns/1ps
module system_domain_model (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic system_reset_out,
    input  wire logic memory_program_key,
    input  wire logic full_erase_key_active,
    output logic      sys_reset_in,
    output logic      mem_program_done_in,
    output logic      erase_done_in,
    output logic      memory_locked_in
);
    logic [3:0] busy_count;

    // Held reset from the port is a real system reset
    assign sys_reset_in = system_reset_out;
    // Sequences take a while, so the key must hold until done
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_count <= 4'h0;
            mem_program_done_in <= 1'b0;
            erase_done_in <= 1'b0;
            memory_locked_in <= 1'b1;
        end else begin
            busy_count <= (memory_program_key || full_erase_key_active) ? busy_count + 4'h1 : 4'h0;
            mem_program_done_in <= memory_program_key && (busy_count == 4'h8);
            erase_done_in <= full_erase_key_active && (busy_count == 4'h8);
            if (erase_done_in) begin
                memory_locked_in <= 1'b0;
            end
        end
    end
endmodule

// file: tb/debug_port_access_regs_tb.sv
`timescale 1ns/1ps
`include "access_layer_consts.svh"
module debug_port_access_regs_tb;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, port_enable_event = 1'b0;
    logic       user_row_key_decoded = 1'b0, memory_program_key_decoded = 1'b0;
    logic       full_erase_key_decoded = 1'b0, neg_ack_request = 1'b0, sys_sleeping_in = 1'b0;
    logic       mem_program_allowed_in = 1'b0, user_row_program_allowed_in = 1'b0;
    logic [2:0] crc_status_in = 3'h0;
    logic [7:0] reg_rdata;
    logic [1:0] port_clock_select;
    logic       phy_enable, port_clock_request, contention_detect_enable, neg_ack_send;
    logic       system_reset_out, system_clock_request, user_row_finish_pulse;
    logic       user_row_key_active, memory_program_key, full_erase_key_active;
    logic       sys_reset_in, memory_locked_in, mem_program_done_in, erase_done_in;
    int         bad_count = 0;
    int         tests_run = 0;
    int         finish_seen = 0;

    always #20 clock = ~clock;

    // Counts finish pulses where they are settled; a long pulse counts once per cycle
    always @(negedge clock) if (user_row_finish_pulse === 1'b1) finish_seen++;

    access_layer_regs access_layer_regs_i (.clock, .rst_n, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .port_enable_event, .user_row_key_decoded,
        .memory_program_key_decoded, .full_erase_key_decoded, .neg_ack_request, .sys_reset_in,
        .sys_sleeping_in, .memory_locked_in, .mem_program_allowed_in,
        .user_row_program_allowed_in, .mem_program_done_in, .erase_done_in, .crc_status_in,
        .phy_enable, .port_clock_request, .port_clock_select, .contention_detect_enable,
        .neg_ack_send, .system_reset_out, .system_clock_request, .user_row_finish_pulse,
        .user_row_key_active, .memory_program_key, .full_erase_key_active);

    system_domain_model system_domain_model_i (.clock, .rst_n, .system_reset_out,
        .memory_program_key, .full_erase_key_active, .sys_reset_in, .mem_program_done_in,
        .erase_done_in, .memory_locked_in);

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // All tasks start and end just after a falling edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        // Idle cycle so a following write never re-raises the strobe at once
        @(negedge clock);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        chk($sformatf("register %h", a), reg_rdata, e);
        @(negedge clock);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask

    // Bounded: a key that never drops ends the run
    task automatic wait_low(ref logic s, input string n);
        for (int i = 0; i < 40 && s !== 1'b0; i++) @(negedge clock);
        chk(n, {7'h00, s}, 8'h00);
        if (s !== 1'b0) give_verdict();
    endtask

    task automatic t_reset();
        chk("select in reset", {6'h00, port_clock_select}, 8'h03);
        chk("phy in reset", {7'h00, phy_enable}, 8'h00);
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        wr(`OFS_PORT_CLOCK_CONTROL, 8'h01);
        pulse(port_enable_event);
        chk("clock request on enable", {7'h00, system_clock_request}, 8'h01);
        rd(`OFS_PORT_CLOCK_CONTROL, 8'h03);
        rd(`OFS_SYSTEM_CONTROL, 8'h01);
        rd(`OFS_SYSTEM_STATUS, 8'h01);
        rd(`OFS_KEY_STATUS, 8'h00);
        rd(`OFS_SYSTEM_RESET_REQUEST, 8'h00);
        rd(`OFS_CRC_STATUS, 8'h00);
        rd(4'h5, 8'h00);
    endtask

    task automatic t_reset_req();
        wr(`OFS_SYSTEM_RESET_REQUEST, 8'h59);
        chk("reset held", {7'h00, system_reset_out}, 8'h01);
        chk("port alive", {7'h00, phy_enable}, 8'h01);
        rd(`OFS_SYSTEM_RESET_REQUEST, 8'h01);
        repeat (3) @(negedge clock);
        rd(`OFS_SYSTEM_STATUS, 8'h21);
        wr(`OFS_SYSTEM_RESET_REQUEST, 8'h58);
        chk("reset released", {7'h00, system_reset_out}, 8'h00);
        rd(`OFS_SYSTEM_RESET_REQUEST, 8'h00);
        repeat (4) @(negedge clock);
        rd(`OFS_SYSTEM_STATUS, 8'h21);
        rd(`OFS_SYSTEM_STATUS, 8'h01);
    endtask

    task automatic t_clock();
        for (int c = 3; c > 0; c--) begin
            wr(`OFS_PORT_CLOCK_CONTROL, 8'(c)); // Brown-out taken as highest
            chk("select", {6'h00, port_clock_select}, 8'(c));
        end
        wr(`OFS_PORT_CLOCK_CONTROL, 8'h00);
        rd(`OFS_PORT_CLOCK_CONTROL, 8'h01);
        wr(`OFS_PORT_CLOCK_CONTROL, 8'hFE);
        rd(`OFS_PORT_CLOCK_CONTROL, 8'h02);
    endtask

    task automatic t_keys();
        wr(`OFS_SYSTEM_CONTROL, 8'h03);
        chk("finish without key", 8'(finish_seen), 8'h00);
        rd(`OFS_SYSTEM_CONTROL, 8'h01);
        pulse(user_row_key_decoded);
        rd(`OFS_KEY_STATUS, 8'h20);
        wr(`OFS_SYSTEM_CONTROL, 8'h03);
        chk("finish pulse", 8'(finish_seen), 8'h01);
        rd(`OFS_SYSTEM_CONTROL, 8'h03);
        wr(`OFS_KEY_STATUS, 8'h00);
        rd(`OFS_KEY_STATUS, 8'h00);
        pulse(memory_program_key_decoded);
        rd(`OFS_KEY_STATUS, 8'h10);
        wait_low(memory_program_key, "program key");
        pulse(full_erase_key_decoded);
        rd(`OFS_KEY_STATUS, 8'h08);
        wait_low(full_erase_key_active, "erase key");
        repeat (4) @(negedge clock);
        rd(`OFS_SYSTEM_STATUS, 8'h00);
    endtask

    task automatic t_status();
        logic [2:0] codes [4] = '{`CRC_STATUS_OFF, `CRC_STATUS_BUSY, `CRC_STATUS_PASS,
                                  `CRC_STATUS_FAIL};
        sys_sleeping_in = 1'b1;
        mem_program_allowed_in = 1'b1;
        user_row_program_allowed_in = 1'b1;
        repeat (4) @(negedge clock);
        rd(`OFS_SYSTEM_STATUS, 8'h1C);
        // User-row programming allowed: finish it with the key held
        pulse(user_row_key_decoded);
        wr(`OFS_SYSTEM_CONTROL, 8'h03);
        chk("finish once allowed", 8'(finish_seen), 8'h02);
        // Memory programming allowed: close it with a system reset
        wr(`OFS_SYSTEM_RESET_REQUEST, `RESET_SIGNATURE);
        chk("reset after programming", {7'h00, system_reset_out}, 8'h01);
        wr(`OFS_SYSTEM_RESET_REQUEST, 8'h00);
        foreach (codes[i]) begin
            crc_status_in = codes[i];
            repeat (4) @(negedge clock);
            rd(`OFS_CRC_STATUS, {5'h00, codes[i]});
        end
        sys_sleeping_in = 1'b0;
    endtask

    task automatic t_ctrl_b();
        wr(`OFS_PORT_CONTROL_B, 8'hFB);
        rd(`OFS_PORT_CONTROL_B, 8'h18);
        chk("contention off", {7'h00, contention_detect_enable}, 8'h00);
        pulse(neg_ack_request);
        chk("nack muted", {7'h00, neg_ack_send}, 8'h00);
        wr(`OFS_PORT_CONTROL_B, 8'h00);
        chk("contention on", {7'h00, contention_detect_enable}, 8'h01);
        pulse(neg_ack_request);
        chk("nack sent", {7'h00, neg_ack_send}, 8'h01);
    endtask

    task automatic t_disable();
        wr(`OFS_SYSTEM_CONTROL, 8'h00);
        chk("clock request low", {7'h00, system_clock_request}, 8'h00);
        wr(`OFS_SYSTEM_CONTROL, 8'h01);
        chk("clock request high", {7'h00, system_clock_request}, 8'h01);
        pulse(user_row_key_decoded);
        wr(`OFS_PORT_CONTROL_B, 8'h18);
        wr(`OFS_PORT_CONTROL_B, 8'h04);
        chk("phy off", {7'h00, phy_enable}, 8'h00);
        chk("port clock off", {7'h00, port_clock_request}, 8'h00);
        chk("sys clock off", {7'h00, system_clock_request}, 8'h00);
        chk("key dropped", {7'h00, user_row_key_active}, 8'h00);
        pulse(port_enable_event);
        rd(`OFS_PORT_CLOCK_CONTROL, 8'h03);
        rd(`OFS_PORT_CONTROL_B, 8'h00);
    endtask

    initial begin
        #(40 * 5000);
        bad_count++;
        give_verdict();
    end

    initial begin
        @(negedge clock);
        t_reset();
        t_reset_req();
        t_clock();
        t_keys();
        t_status();
        t_ctrl_b();
        t_disable();
        give_verdict();
    end
endmodule
